// file: rtl/tlbr_top.sv
// TLB lockdown, context remap and access control for both TLBs
`timescale 1ns/1ps
`include "tlbr_consts.svh"

module tlbr_top (
  input  wire logic                    clock_i,
  input  wire logic                    resetn_i,
  input  wire tlbr_pkg::tlbr_cp_s      cp_i,
  output logic [31:0]                  cp_rdata_o,
  output logic                         cp_rvalid_o,
  input  wire tlbr_pkg::tlbr_req_s     [1:0] req_i,
  output logic [1:0]                   req_ready_o,
  output tlbr_pkg::tlbr_resp_s         [1:0] resp_o,
  output tlbr_pkg::tlbr_walk_s         [1:0] walk_o,
  input  wire tlbr_pkg::tlbr_fill_s    [1:0] fill_i
);
  import tlbr_pkg::*;

  // ****************************************
  // Shared control state
  // ****************************************
  logic        m_reg;
  logic        s_reg;
  logic        r_reg;
  logic [31:0] dom_reg;
  logic [6:0]  pid_reg;
  logic [6:0]  pid_old_reg;
  logic [1:0]  fpend_reg;
  logic [6:0]  ipid;
  tlbr_lock_s  lock_reg [2];
  logic [31:0] rd_next;
  logic        cp_wr;

  assign cp_wr = cp_i.valid & cp_i.write;
  // Fetches already in flight still carry the old identifier
  assign ipid = (fpend_reg != 2'h0) ? pid_old_reg : pid_reg;

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic [31:0] remap(input logic [31:0] va,
                                        input logic [6:0] pid);
    if (va[`TLBR_PID_FIELD] == 7'h0)
      return {pid, va[`TLBR_LOW_FIELD]};
    return va;
  endfunction

  function automatic logic match(input tlbr_entry_s e,
                                 input logic [31:0] mva);
    logic [21:0] t;
    t = mva[`TLBR_TAG_FIELD];
    case (e.size)
      TLBR_SECTION: return e.tag[21:10] == t[21:10];
      TLBR_LARGE:   return e.tag[21:6] == t[21:6];
      TLBR_SMALL:   return e.tag[21:2] == t[21:2];
      default:      return e.tag == t;
    endcase
  endfunction

  function automatic logic [31:0] xlate(input tlbr_entry_s e,
                                        input logic [31:0] mva);
    case (e.size)
      TLBR_SECTION: return {e.pa[21:10], mva[19:0]};
      TLBR_LARGE:   return {e.pa[21:6], mva[15:0]};
      TLBR_SMALL:   return {e.pa[21:2], mva[11:0]};
      default:      return {e.pa, mva[9:0]};
    endcase
  endfunction

  function automatic logic [1:0] ap_sel(input tlbr_entry_s e,
                                        input logic [31:0] mva);
    logic [1:0] q;
    case (e.size)
      TLBR_LARGE: q = mva[`TLBR_LQ_FIELD];
      TLBR_SMALL: q = mva[`TLBR_SQ_FIELD];
      default:    q = 2'h0;
    endcase
    return e.ap[{q, 1'b0} +: 2];
  endfunction

  function automatic logic ap_ok(input logic [1:0] ap,
                                 input logic wr,
                                 input logic usr,
                                 input logic s,
                                 input logic r);
    case (ap)
      `TLBR_AP_NONE:  return !wr && (usr ? r : (s | r));
      `TLBR_AP_PRIV:  return !usr;
      `TLBR_AP_UREAD: return !usr || !wr;
      default:        return 1'b1;
    endcase
  endfunction

  // ****************************************
  // Control and domain registers
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      m_reg   <= 1'b0;
      s_reg   <= 1'b0;
      r_reg   <= 1'b0;
      dom_reg <= `TLBR_DOM_RST;
    end else if (cp_wr && cp_i.crn == `TLBR_CR_CTRL) begin
      m_reg <= cp_i.wdata[`TLBR_CTRL_M];
      s_reg <= cp_i.wdata[`TLBR_CTRL_S];
      r_reg <= cp_i.wdata[`TLBR_CTRL_R];
    end else if (cp_wr && cp_i.crn == `TLBR_CR_DOM) begin
      dom_reg <= cp_i.wdata;
    end
  end

  // ****************************************
  // Context identifier
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      pid_reg     <= `TLBR_PID_RST;
      pid_old_reg <= `TLBR_PID_RST;
      fpend_reg   <= 2'h0;
    end else if (cp_wr && cp_i.crn == `TLBR_CR_PID) begin
      pid_reg     <= cp_i.wdata[`TLBR_PID_FIELD];
      pid_old_reg <= ipid;
      fpend_reg   <= `TLBR_PID_FETCHES;
    end else if (fpend_reg != 2'h0 && req_i[1].valid
                 && req_ready_o[1]) begin
      fpend_reg <= fpend_reg - 2'h1;
    end
  end

  // ****************************************
  // Register read path
  // ****************************************
  // Reserved numbers read as zero; software must not use them
  always_comb begin
    rd_next = 32'h0;
    case (cp_i.crn)
      `TLBR_CR_CTRL: begin
        rd_next[`TLBR_CTRL_M] = m_reg;
        rd_next[`TLBR_CTRL_S] = s_reg;
        rd_next[`TLBR_CTRL_R] = r_reg;
      end
      `TLBR_CR_DOM: rd_next = dom_reg;
      `TLBR_CR_LOCK: begin
        if (cp_i.op2 == 3'h0 || cp_i.op2 == 3'h1) begin
          rd_next[`TLBR_LOCK_BASE] = lock_reg[cp_i.op2[0]].base;
          rd_next[`TLBR_LOCK_VIC]  = lock_reg[cp_i.op2[0]].vic;
          rd_next[`TLBR_LOCK_P]    = lock_reg[cp_i.op2[0]].p;
        end
      end
      `TLBR_CR_PID: rd_next[`TLBR_PID_FIELD] = pid_reg;
      default: rd_next = 32'h0;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      cp_rdata_o  <= 32'h0;
      cp_rvalid_o <= 1'b0;
    end else begin
      cp_rvalid_o <= cp_i.valid & ~cp_i.write;
      if (cp_i.valid && !cp_i.write)
        cp_rdata_o <= rd_next;
    end
  end

  // ****************************************
  // Per-TLB logic: index 0 data, index 1 instruction
  // ****************************************
  for (genvar t = 0; t < 2; t++) begin : g_tlb
    localparam logic [2:0] MY_OP  = 3'(t);
    localparam logic [3:0] MY_CRM = (t == 0) ? `TLBR_CRM_D
                                             : `TLBR_CRM_I;
    tlbr_entry_s   mem [`TLBR_ENTRIES];
    logic [63:0]   vld_reg;
    logic [63:0]   prs_reg;
    tlbr_state_e   st_reg;
    tlbr_req_s     hold_reg;
    logic          hit;
    logic [5:0]    hidx;
    tlbr_entry_s   he;
    logic [1:0]    dom;
    logic          acc_ok;
    logic          fill_now;
    logic          op_mine;
    logic          op_all;
    logic          op_one;

    assign fill_now = (st_reg == TLBR_WALK) && fill_i[t].done;
    assign op_mine  = cp_wr && cp_i.crn == `TLBR_CR_TLBOP
                      && (cp_i.crm == `TLBR_CRM_BOTH
                          || cp_i.crm == MY_CRM);
    assign op_all   = op_mine && cp_i.op2 == `TLBR_OP_ALL;
    assign op_one   = op_mine && cp_i.op2 == `TLBR_OP_ONE;

    // Fully associative lookup, lowest index wins
    always_comb begin
      hit  = 1'b0;
      hidx = 6'h0;
      for (int i = 0; i < `TLBR_ENTRIES; i++) begin
        if (!hit && vld_reg[i] && match(mem[i], hold_reg.va)) begin
          hit  = 1'b1;
          hidx = 6'(i);
        end
      end
    end

    assign he  = mem[hidx];
    assign dom = dom_reg[{he.dom, 1'b0} +: 2];

    always_comb begin
      case (dom)
        `TLBR_DOM_MANAGER: acc_ok = 1'b1;
        `TLBR_DOM_CLIENT:  acc_ok = ap_ok(ap_sel(he, hold_reg.va),
                                          hold_reg.write, hold_reg.user,
                                          s_reg, r_reg);
        default:           acc_ok = 1'b0;
      endcase
    end

    // Lockdown register and victim pointer
    always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
        lock_reg[t] <= `TLBR_LOCK_RST;
      end else if (cp_wr && cp_i.crn == `TLBR_CR_LOCK
                   && cp_i.op2 == MY_OP) begin
        lock_reg[t].base <= cp_i.wdata[`TLBR_LOCK_BASE];
        lock_reg[t].vic  <= cp_i.wdata[`TLBR_LOCK_VIC];
        lock_reg[t].p    <= cp_i.wdata[`TLBR_LOCK_P];
      end else if (fill_now) begin
        // Reload base, not zero, so low entries stay locked
        if (lock_reg[t].vic == `TLBR_LAST_IDX)
          lock_reg[t].vic <= lock_reg[t].base;
        else
          lock_reg[t].vic <= lock_reg[t].vic + 6'h1;
      end
    end

    // Valid and preserve flags; a fill beats a same-cycle flush
    always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
        vld_reg <= 64'h0;
        prs_reg <= 64'h0;
      end else begin
        if (op_all)
          vld_reg <= vld_reg & prs_reg;
        for (int i = 0; i < `TLBR_ENTRIES; i++) begin
          if (op_one && vld_reg[i] && match(mem[i], cp_i.wdata))
            vld_reg[i] <= 1'b0;
        end
        if (fill_now) begin
          vld_reg[lock_reg[t].vic] <= 1'b1;
          prs_reg[lock_reg[t].vic] <= lock_reg[t].p;
        end
      end
    end

    // Entry storage has no reset; valid bits guard it
    always_ff @(posedge clock_i) begin
      if (fill_now) begin
        mem[lock_reg[t].vic]     <= fill_i[t].ent;
        mem[lock_reg[t].vic].tag <= hold_reg.va[`TLBR_TAG_FIELD];
      end
    end

    // Request sequencing
    always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
        st_reg         <= TLBR_IDLE;
        hold_reg       <= '0;
        req_ready_o[t] <= 1'b1;
        resp_o[t]      <= '0;
        walk_o[t]      <= '0;
      end else begin
        resp_o[t].valid <= 1'b0;
        case (st_reg)
          TLBR_IDLE: begin
            if (req_i[t].valid) begin
              hold_reg       <= req_i[t];
              hold_reg.va    <= remap(req_i[t].va,
                                      (t == 1) ? ipid : pid_reg);
              req_ready_o[t] <= 1'b0;
              st_reg         <= TLBR_CHECK;
            end
          end
          TLBR_CHECK: begin
            if (!m_reg) begin
              resp_o[t].valid      <= 1'b1;
              resp_o[t].abort      <= 1'b0;
              resp_o[t].cacheable  <= 1'b0;
              resp_o[t].bufferable <= 1'b0;
              resp_o[t].pa         <= hold_reg.va;
              req_ready_o[t]       <= 1'b1;
              st_reg               <= TLBR_IDLE;
            end else if (hit) begin
              resp_o[t].valid      <= 1'b1;
              resp_o[t].abort      <= ~acc_ok;
              resp_o[t].cacheable  <= acc_ok & he.c;
              resp_o[t].bufferable <= acc_ok & he.b;
              resp_o[t].pa         <= xlate(he, hold_reg.va);
              req_ready_o[t]       <= 1'b1;
              st_reg               <= TLBR_IDLE;
            end else begin
              walk_o[t].req <= 1'b1;
              walk_o[t].mva <= hold_reg.va;
              st_reg        <= TLBR_WALK;
            end
          end
          TLBR_WALK: begin
            // Retry the lookup once the new entry is written
            if (fill_i[t].done) begin
              walk_o[t].req <= 1'b0;
              st_reg        <= TLBR_CHECK;
            end
          end
          default: st_reg <= TLBR_IDLE;
        endcase
      end
    end
  end

endmodule // tlbr_top

// file: rtl/tlbr_consts.svh
// Constants for the TLB lockdown and context remap block
`ifndef TLBR_CONSTS_SVH
`define TLBR_CONSTS_SVH

// ****************************************
// Sizes
// ****************************************
`define TLBR_ENTRIES 64
`define TLBR_LAST_IDX 6'h3f
`define TLBR_PID_FETCHES 2'h2

// ****************************************
// Coprocessor register numbers
// ****************************************
`define TLBR_CR_CTRL 4'h1
`define TLBR_CR_DOM 4'h3
`define TLBR_CR_TLBOP 4'h8
`define TLBR_CR_LOCK 4'ha
`define TLBR_CR_PID 4'hd
`define TLBR_OP_ALL 3'h0
`define TLBR_OP_ONE 3'h1
`define TLBR_CRM_BOTH 4'h7
`define TLBR_CRM_I 4'h5
`define TLBR_CRM_D 4'h6

// ****************************************
// Reset values
// ****************************************
`define TLBR_LOCK_RST 13'h0
`define TLBR_PID_RST 7'h0
`define TLBR_DOM_RST 32'h0

// ****************************************
// Field positions
// ****************************************
`define TLBR_CTRL_M 0
`define TLBR_CTRL_S 8
`define TLBR_CTRL_R 9
`define TLBR_LOCK_BASE 31:26
`define TLBR_LOCK_VIC 25:20
`define TLBR_LOCK_P 0
`define TLBR_PID_FIELD 31:25
`define TLBR_LOW_FIELD 24:0
`define TLBR_TAG_FIELD 31:10
`define TLBR_LQ_FIELD 15:14
`define TLBR_SQ_FIELD 11:10

// ****************************************
// Domain and permission codes
// ****************************************
`define TLBR_DOM_CLIENT 2'h1
`define TLBR_DOM_MANAGER 2'h3
`define TLBR_AP_NONE 2'h0
`define TLBR_AP_PRIV 2'h1
`define TLBR_AP_UREAD 2'h2

`endif

// file: rtl/tlbr_pkg.sv
// Types for the TLB lockdown and context remap block
package tlbr_pkg;
  typedef enum logic [1:0] {
    TLBR_SECTION, TLBR_LARGE, TLBR_SMALL, TLBR_TINY
  } tlbr_size_e;
  typedef enum logic [1:0] {
    TLBR_IDLE, TLBR_CHECK, TLBR_WALK
  } tlbr_state_e;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [3:0]  crn;
    logic [2:0]  op2;
    logic [3:0]  crm;
    logic [31:0] wdata;
  } tlbr_cp_s;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        user;
    logic [31:0] va;
  } tlbr_req_s;
  typedef struct packed {
    logic        valid;
    logic        abort;
    logic        cacheable;
    logic        bufferable;
    logic [31:0] pa;
  } tlbr_resp_s;
  typedef struct packed {
    logic [21:0] tag;
    logic [21:0] pa;
    tlbr_size_e  size;
    logic [3:0]  dom;
    logic [7:0]  ap;
    logic        c;
    logic        b;
  } tlbr_entry_s;
  typedef struct packed {
    logic        done;
    tlbr_entry_s ent;
  } tlbr_fill_s;
  typedef struct packed {
    logic        req;
    logic [31:0] mva;
  } tlbr_walk_s;
  typedef struct packed {
    logic [5:0] base;
    logic [5:0] vic;
    logic       p;
  } tlbr_lock_s;
endpackage

// file: sim/tlbr_walker.sv
// Table walk responder standing in for page table memory
`timescale 1ns/1ps
module tlbr_walker (
  input  wire logic                 clock_i,
  input  wire logic                 resetn_i,
  input  wire tlbr_pkg::tlbr_walk_s walk_i,
  input  wire logic [3:0]           delay_i,
  input  wire tlbr_pkg::tlbr_size_e size_i,
  input  wire logic [7:0]           ap_i,
  output tlbr_pkg::tlbr_fill_s      fill_o
);
  import tlbr_pkg::*;
  logic [3:0] cnt_reg;

  // Every walk maps the chosen page size, top address bit flipped
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      fill_o  <= '0;
      cnt_reg <= 4'h0;
    end else begin
      // Entry lines toggle while idle so stale data never looks valid
      fill_o.ent  <= ~fill_o.ent;
      fill_o.done <= 1'b0;
      cnt_reg     <= 4'h0;
      if (walk_i.req && !fill_o.done) begin
        cnt_reg <= cnt_reg + 4'h1;
        if (cnt_reg == delay_i) begin
          fill_o.done <= 1'b1;
          fill_o.ent  <= '{walk_i.mva[31:10],
            walk_i.mva[31:10] ^ 22'h20_0000, size_i,
            4'h0, ap_i, 1'b1, 1'b1};
        end
      end
    end
  end
endmodule // tlbr_walker

// file: sim/tlbr_checker.sv
// Port timing checks for the TLB lockdown and remap block
`timescale 1ns/1ps
module tlbr_checker (
  input wire logic                      clock_i,
  input wire logic                      resetn_i,
  input wire tlbr_pkg::tlbr_cp_s        cp_i,
  input wire logic [31:0]               cp_rdata_o,
  input wire logic                      cp_rvalid_o,
  input wire tlbr_pkg::tlbr_req_s [1:0] req_i,
  input wire logic [1:0]                req_ready_o,
  input wire tlbr_pkg::tlbr_resp_s [1:0] resp_o,
  input wire tlbr_pkg::tlbr_walk_s [1:0] walk_o,
  input wire tlbr_pkg::tlbr_fill_s [1:0] fill_i
);
  import tlbr_pkg::*;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  sequence s_rd;
    cp_i.valid && !cp_i.write;
  endsequence
  sequence s_take;
    req_ready_o[0] && req_i[0].valid;
  endsequence
  sequence s_fill;
    walk_o[0].req && fill_i[0].done;
  endsequence

  a_read_answer: assert property (s_rd |=> cp_rvalid_o)
    else $error("read not answered");
  a_no_spur_rvalid: assert property (
    !cp_i.valid || cp_i.write |=> !cp_rvalid_o)
    else $error("read answer without read");
  a_lock_mid_zero: assert property (
    s_rd ##0 cp_i.crn == 4'ha |=> cp_rdata_o[19:1] == 19'h0)
    else $error("lock read middle bits set");
  a_pid_low_zero: assert property (
    s_rd ##0 cp_i.crn == 4'hd |=> cp_rdata_o[24:0] == 25'h0)
    else $error("identifier read low bits set");
  a_take_busy: assert property (s_take |=> !req_ready_o[0])
    else $error("ready stayed high after take");
  a_answer_or_walk: assert property (
    s_take |-> ##2 (resp_o[0].valid || walk_o[0].req))
    else $error("no answer or walk two cycles after take");
  a_walk_holds: assert property (
    walk_o[1].req && !fill_i[1].done |=> walk_o[1].req)
    else $error("walk request dropped before fill");
  a_resp_after_fill: assert property (s_fill |-> ##2 resp_o[0].valid)
    else $error("no answer two cycles after fill");
  a_abort_uncached: assert property (
    resp_o[0].valid && resp_o[0].abort
      |-> !resp_o[0].cacheable && !resp_o[0].bufferable)
    else $error("aborted access marked cacheable");
endmodule // tlbr_checker

bind tlbr_top tlbr_checker chk (.clock_i, .resetn_i, .cp_i, .cp_rdata_o,
  .cp_rvalid_o, .req_i, .req_ready_o, .resp_o, .walk_o, .fill_i);

// file: sim/tlbr_top_tb.sv
// Self-checking bench for the TLB lockdown and remap block
`timescale 1ns/1ps
module tlbr_top_tb;
  import tlbr_pkg::*;
  localparam logic [31:0] MSK = 32'hfff0_0001;
  localparam logic [31:0] VA_A = 32'h1010_0000;
  localparam logic [31:0] VA_B = 32'h1020_0000;
  localparam logic [31:0] VA_C = 32'h2030_0000;
  localparam logic [31:0] VA_D = 32'h3000_0000;
  // Read-back order after reset: D lock, I lock, identifier, control
  localparam logic [15:0] RDN = 16'h1daa;
  logic             clock_i = 1'b0;
  logic             resetn_i = 1'b0;
  tlbr_cp_s         cp = '0;
  logic [31:0]      rdata;
  logic             rvalid;
  tlbr_req_s [1:0]  req = '0;
  logic [1:0]       rdy;
  tlbr_resp_s [1:0] resp;
  tlbr_walk_s [1:0] walk;
  tlbr_fill_s [1:0] fill;
  logic [3:0]       dly = 4'h0;
  tlbr_size_e       sz = TLBR_SECTION;
  logic [7:0]       apv = 8'hff;
  logic [1:0]       wu = 2'h0;
  logic [31:0]      q;
  int               n_fail = 0;
  int               n_tests = 0;
  int               n_walk = 0;
  int               cyc = 0;

  always #20 clock_i = ~clock_i;

  tlbr_top dut (.clock_i, .resetn_i, .cp_i(cp), .cp_rdata_o(rdata),
    .cp_rvalid_o(rvalid), .req_i(req), .req_ready_o(rdy),
    .resp_o(resp), .walk_o(walk), .fill_i(fill));
  tlbr_walker w0 (.clock_i, .resetn_i, .walk_i(walk[0]),
    .delay_i(dly), .size_i(sz), .ap_i(apv), .fill_o(fill[0]));
  tlbr_walker w1 (.clock_i, .resetn_i, .walk_i(walk[1]),
    .delay_i(dly), .size_i(sz), .ap_i(apv), .fill_o(fill[1]));

  // ******************
  // Helpers
  // ******************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge clock_i) begin
    cyc++;
    if (fill[0].done || fill[1].done)
      n_walk++;
    if (cyc == 5000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cpx(input logic w, input logic [3:0] n,
                     input logic [2:0] o, input logic [3:0] m,
                     input logic [31:0] d);
    int k;
    @(negedge clock_i);
    cp = '{1'b1, w, n, o, m, d};
    @(negedge clock_i);
    cp.valid = 1'b0;
    for (k = 0; k < 4 && !w && rvalid !== 1'b1; k++)
      @(negedge clock_i);
    q = rdata;
  endtask

  // Flags are abort, cacheable, bufferable; ew is walks expected
  task automatic xl(input int s, input logic [31:0] va,
                    input logic [31:0] ep, input logic [2:0] ef,
                    input int ew);
    int k;
    int nw;
    nw = n_walk;
    @(negedge clock_i);
    req[s] = '{1'b1, wu[1], wu[0], va};
    for (k = 0; k < 9 && rdy[s] !== 1'b1; k++)
      @(negedge clock_i);
    @(negedge clock_i);
    req[s].valid = 1'b0;
    for (k = 0; k < 60 && resp[s].valid !== 1'b1; k++)
      @(negedge clock_i);
    chk(resp[s].pa, ep);
    chk({resp[s].abort, resp[s].cacheable, resp[s].bufferable}, ef);
    @(negedge clock_i);
    chk(n_walk - nw, ew);
  endtask

  function automatic logic [31:0] f(input logic [31:0] va);
    return {va[31:20] ^ 12'h800, va[19:0]};
  endfunction

  // ******************
  // Main sequence
  // ******************
  initial begin
    repeat (12) @(negedge clock_i);
    resetn_i = 1'b1;
    for (int i = 0; i < 4; i++) begin
      cpx(1'b0, RDN[4*i +: 4], 3'(i & 1), 4'h0, 32'h0);
      chk(q, 32'h0);
    end
    cpx(1'b1, 4'ha, 3'h1, 4'h0, 32'h17e0_0001);
    cpx(1'b0, 4'ha, 3'h1, 4'h0, 32'h0);
    chk(q & MSK, 32'h17e0_0001);
    cpx(1'b0, 4'ha, 3'h0, 4'h0, 32'h0);
    chk(q & MSK, 32'h0);
    cpx(1'b1, 4'hd, 3'h0, 4'h0, 32'h0600_0000);
    cpx(1'b0, 4'hd, 3'h0, 4'h0, 32'h0);
    chk(q, 32'h0600_0000);
    xl(0, 32'h0000_1234, 32'h0600_1234, 3'b000, 0);
    xl(0, 32'h0400_0000, 32'h0400_0000, 3'b000, 0);
    for (int i = 0; i < 3; i++)
      xl(1, 32'h100, i < 2 ? 32'h100 : 32'h0600_0100, 3'b000, 0);
    cpx(1'b1, 4'h3, 3'h0, 4'h0, 32'h3);
    cpx(1'b1, 4'h1, 3'h0, 4'h0, 32'h1);
    dly = 4'h7;
    xl(1, VA_A, f(VA_A), 3'b011, 1);
    cpx(1'b1, 4'ha, 3'h1, 4'h0, 32'h17f0_0000);
    xl(1, VA_B, f(VA_B), 3'b011, 1);
    xl(1, VA_A, f(VA_A), 3'b011, 0);
    cpx(1'b0, 4'ha, 3'h1, 4'h0, 32'h0);
    chk(q & MSK, 32'h1450_0000);
    xl(0, VA_C, f(VA_C), 3'b011, 1);
    dly = 4'h0;
    cpx(1'b1, 4'h8, 3'h0, 4'h5, 32'h0);
    xl(1, VA_A, f(VA_A), 3'b011, 0);
    xl(1, VA_B, f(VA_B), 3'b011, 1);
    xl(0, VA_C, f(VA_C), 3'b011, 0);
    cpx(1'b1, 4'h8, 3'h1, 4'h5, VA_A);
    xl(1, VA_A, f(VA_A), 3'b011, 1);
    cpx(1'b0, 4'ha, 3'h0, 4'h0, 32'h0);
    chk(q & MSK, 32'h0010_0000);
    cpx(1'b1, 4'h3, 3'h0, 4'h0, 32'h0);
    xl(0, VA_C, f(VA_C), 3'b100, 0);
    // Client domain, small page, one permission code per quarter
    cpx(1'b1, 4'h3, 3'h0, 4'h0, 32'h1);
    sz = TLBR_SMALL;
    apv = 8'he4;
    xl(0, VA_D, f(VA_D), 3'b100, 1);
    xl(0, VA_D + 32'h400, f(VA_D + 32'h400), 3'b011, 0);
    wu = 2'h3;
    xl(0, VA_D + 32'h800, f(VA_D + 32'h800), 3'b100, 0);
    wu = 2'h0;
    cpx(1'b1, 4'h1, 3'h0, 4'h0, 32'h101);
    xl(0, VA_D, f(VA_D), 3'b011, 0);
    complete_run();
  end
endmodule // tlbr_top_tb
